// [fpc_host.sv]
// host sequencer issuing flash program, erase and region commands
// Function
// - secure region entered by three cycles, left by four-cycle exit.
// - program is two unlocks, set-up, then address and data.
// - bypass entry is two unlocks and 20h, then A0h plus data.
// - in bypass only bypass program and bypass reset are valid; the code also accepts a read.
// - chip erase is six cycles ending in the chip-erase command.
// - sector erase is six cycles ending with sector address and 30h.
// - 50 us window allows extra sector-address-plus-30h writes.
// - only 30h, B0h, F0h may be written inside the window.
//
// Our own choices: the strobed register port and the register addresses.
`include "fpc_defines.svh"
`default_nettype none
module fpc_host
  import fpc_pkg::*;
#(
  parameter int WINDOW_CYC = `FPC_WINDOW_CYC
) (
  input wire logic sys_clk, // 125 MHz clock
  input wire logic rst, // sync reset, active high
  input wire logic ce, // clock enable
  input wire logic [3:0] reg_addr, // register address
  input wire logic [31:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [31:0] reg_rdata, // read data, next cycle
  output logic [21:0] fl_addr, // flash address
  output logic [15:0] fl_dq_out, // flash data out
  output logic fl_dq_oe, // flash data drive enable
  input wire logic [15:0] fl_dq_in, // flash data in
  output logic fl_we_n, // write strobe to flash
  output logic fl_oe_n, // output enable to flash
  output logic fl_ce_n, // chip enable to flash
  output logic fl_byte_n, // byte-mode select, low for byte
  output logic fl_accel_hv, // request high voltage on protect pin
  output logic fl_reset_n, // hardware reset to flash
  input wire logic ready_busy_out_n // flash ready/busy, low busy
);
  import fpc_pkg::*;
  typedef enum logic [2:0] {
    FPC_IDLE, FPC_ISSUE, FPC_WAIT, FPC_POLL, FPC_WINDOW
  } fpc_state_t;
  fpc_state_t st_q;
  fpc_wr_if wif ();
  logic [15:0] dq_m_q, dq_s_q;
  logic rb_m_q, rb_s_q;
  logic [31:0] ctrl_q;
  logic [21:0] addr_q, sect_q;
  logic [15:0] data_q;
  logic [2:0] idx_q;
  fpc_op_t op_q;
  logic sec_q, byp_q, err_q, tmo_q, hwrst_q, rdone_q;
  logic [15:0] last_rd_q;
  logic [13:0] win_q;
  fpc_cycle_t cyc;
  logic [2:0] op_len;
  fpc_op_t new_op;
  logic go, busy, is_byte, op_ok, in_alg, susp_ok;
  assign is_byte = !ctrl_q[`FPC_CTRL_BYTE];
  assign fl_byte_n = ctrl_q[`FPC_CTRL_BYTE];
  assign fl_accel_hv = ctrl_q[`FPC_CTRL_ACCEL] && !sec_q;
  assign fl_reset_n = !hwrst_q;
  assign new_op = fpc_op_t'(reg_wdata[3:0]);
  assign go = reg_wr && reg_addr == `FPC_REG_CTRL && ce;
  assign busy = st_q != FPC_IDLE && st_q != FPC_WINDOW;
  // suspend may break into a running sector erase
  assign susp_ok = st_q == FPC_POLL && new_op == FPC_OP_SUSPEND &&
    (op_q == FPC_OP_SECT_ERASE || op_q == FPC_OP_SECT_ADD);
  assign in_alg = !rb_s_q;
  // window accepts only extra sector, suspend, reset
  assign op_ok = st_q == FPC_WINDOW ? (new_op == FPC_OP_SECT_ADD ||
    new_op == FPC_OP_SUSPEND || new_op == FPC_OP_RESET) :
    // bypass mode accepts only bypass program, exit and read
    byp_q ? (new_op == FPC_OP_BYP_PROG || new_op == FPC_OP_BYP_EXIT ||
    new_op == FPC_OP_READ) :
    // no bypass and no region access while an algorithm runs
    in_alg ? (new_op == FPC_OP_SUSPEND || new_op == FPC_OP_READ) :
    !(sec_q && (new_op == FPC_OP_BYP_ENTER));
  always_comb begin
    case (op_q)
      FPC_OP_PROG: op_len = 3'd4;
      FPC_OP_BYP_ENTER: op_len = 3'd3;
      FPC_OP_BYP_PROG: op_len = 3'd2;
      FPC_OP_BYP_EXIT: op_len = 3'd2;
      FPC_OP_CHIP_ERASE: op_len = 3'd6;
      FPC_OP_SECT_ERASE: op_len = 3'd6;
      FPC_OP_SEC_ENTER: op_len = 3'd3;
      FPC_OP_SEC_EXIT: op_len = 3'd4;
      default: op_len = 3'd1;
    endcase
  end
  // unlock pair address differs in byte mode
  logic [11:0] u1, u2;
  assign u1 = is_byte ? `FPC_ADR_U1B : `FPC_ADR_U1;
  assign u2 = is_byte ? `FPC_ADR_U2B : `FPC_ADR_U2;
  always_comb begin
    cyc.addr = {10'h000, u1};
    cyc.data = {8'h00, `FPC_CMD_UNLK1};
    case ({op_q, idx_q})
      {FPC_OP_PROG, 3'd1}, {FPC_OP_BYP_ENTER, 3'd1},
      {FPC_OP_CHIP_ERASE, 3'd1}, {FPC_OP_SECT_ERASE, 3'd1},
      {FPC_OP_CHIP_ERASE, 3'd4}, {FPC_OP_SECT_ERASE, 3'd4},
      {FPC_OP_SEC_ENTER, 3'd1}, {FPC_OP_SEC_EXIT, 3'd1}:
        cyc = '{{10'h000, u2}, {8'h00, `FPC_CMD_UNLK2}};
      {FPC_OP_PROG, 3'd2}: cyc.data = {8'h00, `FPC_CMD_PROG};
      {FPC_OP_BYP_ENTER, 3'd2}: cyc.data = {8'h00, `FPC_CMD_BYPASS};
      {FPC_OP_CHIP_ERASE, 3'd2}, {FPC_OP_SECT_ERASE, 3'd2}:
        cyc.data = {8'h00, `FPC_CMD_ERASE};
      {FPC_OP_SEC_ENTER, 3'd2}: cyc.data = {8'h00, `FPC_CMD_SEC_EN};
      {FPC_OP_SEC_EXIT, 3'd2}: cyc.data = {8'h00, `FPC_CMD_EXIT1};
      {FPC_OP_SEC_EXIT, 3'd3}: cyc.data = {8'h00, `FPC_CMD_EXIT2};
      {FPC_OP_CHIP_ERASE, 3'd5}: cyc.data = {8'h00, `FPC_CMD_CHIP};
      {FPC_OP_SECT_ERASE, 3'd5}, {FPC_OP_SECT_ADD, 3'd0}:
        cyc = '{sect_q, {8'h00, `FPC_CMD_SECT}};
      {FPC_OP_PROG, 3'd3}, {FPC_OP_BYP_PROG, 3'd1}:
        cyc = '{addr_q, is_byte ? {8'h00, data_q[7:0]} : data_q};
      {FPC_OP_BYP_PROG, 3'd0}: cyc.data = {8'h00, `FPC_CMD_PROG};
      {FPC_OP_BYP_EXIT, 3'd0}: cyc.data = {8'h00, `FPC_CMD_EXIT1};
      {FPC_OP_BYP_EXIT, 3'd1}: cyc.data = {8'h00, `FPC_CMD_EXIT2};
      {FPC_OP_SUSPEND, 3'd0}: cyc = '{sect_q, {8'h00, `FPC_CMD_SUSP}};
      {FPC_OP_RESUME, 3'd0}: cyc = '{sect_q, {8'h00, `FPC_CMD_RESUME}};
      {FPC_OP_RESET, 3'd0}: cyc.data = {8'h00, `FPC_CMD_RESET};
      {FPC_OP_READ, 3'd0}: cyc.addr = addr_q;
      default: ;
    endcase
  end
  assign wif.req = st_q == FPC_ISSUE;
  assign wif.rd = op_q == FPC_OP_READ;
  assign wif.addr = cyc.addr;
  assign wif.data = cyc.data;
  fpc_pin_engine u_pins (
    .sys_clk(sys_clk), .rst(rst), .ce(ce), .bus(wif.pins),
    .dq_in_s(dq_s_q), .fl_addr(fl_addr), .fl_dq_out(fl_dq_out),
    .fl_dq_oe(fl_dq_oe), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n),
    .fl_ce_n(fl_ce_n)
  );
  logic last_cyc, alg_op;
  assign last_cyc = idx_q == op_len - 3'd1;
  assign alg_op = op_q == FPC_OP_PROG || op_q == FPC_OP_BYP_PROG ||
    op_q == FPC_OP_CHIP_ERASE;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dq_m_q <= '0; dq_s_q <= '0; rb_m_q <= 1'b1; rb_s_q <= 1'b1;
    end else if (ce) begin
      dq_m_q <= fl_dq_in; dq_s_q <= dq_m_q;
      rb_m_q <= ready_busy_out_n; rb_s_q <= rb_m_q;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= FPC_IDLE; ctrl_q <= '0; addr_q <= '0; data_q <= '0;
      sect_q <= '0; idx_q <= '0; op_q <= FPC_OP_NONE;
      sec_q <= 1'b0; byp_q <= 1'b0; err_q <= 1'b0; tmo_q <= 1'b0;
      hwrst_q <= 1'b0; win_q <= '0; last_rd_q <= '0; rdone_q <= 1'b0;
    end else if (ce) begin
      hwrst_q <= 1'b0;
      if (reg_wr && reg_addr == `FPC_REG_ADDR) addr_q <= reg_wdata[21:0];
      if (reg_wr && reg_addr == `FPC_REG_DATA) data_q <= reg_wdata[15:0];
      if (reg_wr && reg_addr == `FPC_REG_SECT) sect_q <= reg_wdata[21:0];
      if (reg_wr && reg_addr == `FPC_REG_STAT) begin
        err_q <= 1'b0; rdone_q <= 1'b0;
      end
      if (go && reg_wdata[31]) begin
        // hardware reset aborts any algorithm
        hwrst_q <= 1'b1; st_q <= FPC_IDLE; byp_q <= 1'b0; sec_q <= 1'b0;
      end else if (go) begin
        // mode bits frozen while a bus sequence is running
        if (!busy) ctrl_q <= reg_wdata;
        if (new_op != FPC_OP_NONE) begin
          if ((!busy || susp_ok) && op_ok) begin
            op_q <= new_op; idx_q <= '0; st_q <= FPC_ISSUE;
            tmo_q <= 1'b0;
          end else err_q <= 1'b1;
        end
      end
      case (st_q)
        FPC_ISSUE: st_q <= FPC_WAIT;
        FPC_WAIT: if (wif.done) begin
          if (!last_cyc) begin
            idx_q <= idx_q + 3'd1; st_q <= FPC_ISSUE;
          end else begin
            case (op_q)
              FPC_OP_SEC_ENTER: sec_q <= 1'b1;
              FPC_OP_SEC_EXIT: sec_q <= 1'b0;
              FPC_OP_BYP_ENTER: byp_q <= 1'b1;
              FPC_OP_BYP_EXIT, FPC_OP_RESET: byp_q <= 1'b0;
              FPC_OP_READ: begin
                last_rd_q <= wif.rdata; rdone_q <= 1'b1;
              end
              default: ;
            endcase
            win_q <= '0;
            st_q <= (op_q == FPC_OP_SECT_ERASE || op_q == FPC_OP_SECT_ADD)
              ? FPC_WINDOW : alg_op ? FPC_POLL : FPC_IDLE;
          end
        end
        // window timed from last strobe rise
        FPC_WINDOW: if (!go) begin
          if (win_q == 14'(WINDOW_CYC - 1)) begin
            tmo_q <= 1'b1; st_q <= FPC_POLL;
          end else win_q <= win_q + 14'h1;
        end
        // wait for ready to return
        FPC_POLL: if (win_q[3] && rb_s_q) st_q <= FPC_IDLE;
          else if (!win_q[3]) win_q <= win_q + 14'h1;
        default: ;
      endcase
      if (go && !reg_wdata[31] && susp_ok && op_ok)
        st_q <= FPC_ISSUE;
      if (fl_accel_hv) byp_q <= 1'b1;
    end
  end
  logic [31:0] rd_mux;
  assign rd_mux = reg_addr == `FPC_REG_CTRL ? ctrl_q :
    reg_addr == `FPC_REG_ADDR ? {10'h000, addr_q} :
    reg_addr == `FPC_REG_DATA ? {16'h0000, data_q} :
    reg_addr == `FPC_REG_SECT ? {10'h000, sect_q} :
    reg_addr == `FPC_REG_RDATA ? {16'h0000, last_rd_q} :
    reg_addr == `FPC_REG_STAT ? {24'h0, tmo_q, rdone_q, in_alg, err_q,
      byp_q, sec_q, st_q == FPC_WINDOW, st_q != FPC_IDLE} : 32'h0;
  always_ff @(posedge sys_clk) begin
    if (rst) reg_rdata <= '0;
    else if (ce && reg_rd) reg_rdata <= rd_mux;
  end
endmodule : fpc_host
`default_nettype wire

// [fpc_defines.svh]
// constants for the flash command sequencer host
`ifndef FPC_DEFINES_SVH
`define FPC_DEFINES_SVH
`define FPC_REG_CTRL 4'h0
`define FPC_REG_ADDR 4'h1
`define FPC_REG_DATA 4'h2
`define FPC_REG_STAT 4'h3
`define FPC_REG_RDATA 4'h4
`define FPC_REG_SECT 4'h5
`define FPC_CTRL_BYTE 8
`define FPC_CTRL_ACCEL 9
`define FPC_CMD_UNLK1 8'hAA
`define FPC_CMD_UNLK2 8'h55
`define FPC_CMD_PROG 8'hA0
`define FPC_CMD_BYPASS 8'h20
`define FPC_CMD_ERASE 8'h80
`define FPC_CMD_CHIP 8'h10
`define FPC_CMD_SECT 8'h30
`define FPC_CMD_SUSP 8'hB0
`define FPC_CMD_RESUME 8'h30
`define FPC_CMD_RESET 8'hF0
`define FPC_CMD_SEC_EN 8'h88
`define FPC_CMD_EXIT1 8'h90
`define FPC_CMD_EXIT2 8'h00
`define FPC_ADR_U1 12'h555
`define FPC_ADR_U2 12'h2AA
`define FPC_ADR_U1B 12'hAAA
`define FPC_ADR_U2B 12'h555
`define FPC_CLK_MHZ 125
`define FPC_WINDOW_US 50
`define FPC_WINDOW_CYC (`FPC_WINDOW_US * `FPC_CLK_MHZ)
`define FPC_WE_CYC 4
`endif

// [fpc_pkg.sv]
// types for the flash command sequencer host
`default_nettype none
package fpc_pkg;
  typedef enum logic [3:0] {
    FPC_OP_NONE, FPC_OP_PROG, FPC_OP_BYP_ENTER, FPC_OP_BYP_PROG,
    FPC_OP_BYP_EXIT, FPC_OP_CHIP_ERASE, FPC_OP_SECT_ERASE,
    FPC_OP_SECT_ADD, FPC_OP_SUSPEND, FPC_OP_RESUME, FPC_OP_RESET,
    FPC_OP_SEC_ENTER, FPC_OP_SEC_EXIT, FPC_OP_READ
  } fpc_op_t;
  typedef struct packed {
    logic [21:0] addr;
    logic [15:0] data;
  } fpc_cycle_t;
endpackage : fpc_pkg
`default_nettype wire

// [fpc_wr_if.sv]
// strobe request channel between sequencer and pin engine
`default_nettype none
interface fpc_wr_if;
  logic req;
  logic rd;
  logic [21:0] addr;
  logic [15:0] data;
  logic done;
  logic [15:0] rdata;
  modport seq (output req, output rd, output addr, output data,
    input done, input rdata);
  modport pins (input req, input rd, input addr, input data,
    output done, output rdata);
endinterface : fpc_wr_if
`default_nettype wire

// [fpc_pin_engine.sv]
// one flash bus cycle: write strobe pulse or read sample
`include "fpc_defines.svh"
`default_nettype none
module fpc_pin_engine #(
  parameter int STROBE_CYC = `FPC_WE_CYC
) (
  input wire logic sys_clk, // clock
  input wire logic rst, // sync reset
  input wire logic ce, // clock enable
  fpc_wr_if.pins bus, // request channel
  input wire logic [15:0] dq_in_s, // synchronised flash data
  output logic [21:0] fl_addr, // flash address
  output logic [15:0] fl_dq_out, // flash data out
  output logic fl_dq_oe, // flash data drive
  output logic fl_we_n, // write strobe
  output logic fl_oe_n, // output enable
  output logic fl_ce_n // chip enable
);
  logic [3:0] cnt_q;
  logic busy_q, rd_q;
  logic last;
  assign last = busy_q && cnt_q == 4'(STROBE_CYC + 2);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q <= 4'h0; busy_q <= 1'b0; rd_q <= 1'b0; fl_addr <= '0;
      fl_dq_out <= '0; fl_dq_oe <= 1'b0; fl_we_n <= 1'b1;
      fl_oe_n <= 1'b1; fl_ce_n <= 1'b1; bus.done <= 1'b0;
      bus.rdata <= '0;
    end else if (ce) begin
      bus.done <= last;
      if (bus.req && !busy_q) begin
        busy_q <= 1'b1; rd_q <= bus.rd; cnt_q <= 4'h0;
        fl_addr <= bus.addr; fl_dq_out <= bus.data;
        fl_dq_oe <= !bus.rd; fl_ce_n <= 1'b0;
      end else if (busy_q) begin
        cnt_q <= cnt_q + 4'h1;
        // address latched on the falling strobe, data on the rising
        if (cnt_q == 4'h0) begin
          fl_we_n <= rd_q; fl_oe_n <= !rd_q;
        end
        if (cnt_q == 4'(STROBE_CYC)) begin
          fl_we_n <= 1'b1; fl_oe_n <= 1'b1;
          if (rd_q) bus.rdata <= dq_in_s;
        end
        if (last) begin
          busy_q <= 1'b0; fl_ce_n <= 1'b1; fl_dq_oe <= 1'b0;
        end
      end
    end
  end
endmodule : fpc_pin_engine
`default_nettype wire

// [fpc_flash_model.sv]
// behavioural flash device answering the host's bus cycles
`default_nettype none
module fpc_flash_model #(
  parameter int BUSY_CYC = 40
) (
  input wire logic sys_clk, // clock
  input wire logic [21:0] fl_addr, // address
  input wire logic [15:0] fl_dq_out, // data from host
  input wire logic fl_we_n, // write strobe
  input wire logic fl_oe_n, // output enable
  input wire logic fl_ce_n, // chip enable
  input wire logic fl_byte_n, // byte select
  input wire logic fl_reset_n, // hardware reset
  output logic [15:0] fl_dq_in, // data to host
  output logic ready_busy_out_n // low while busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic we_q = 1'b1;
  logic [7:0] last = 8'h00;
  logic arm = 1'b0;
  logic byp = 1'b0;
  logic [15:0] held = 16'h0000;
  logic [15:0] mem [16];
  logic [15:0] wd;
  int busy = 0;
  initial for (int i = 0; i < 16; i++) mem[i] = 16'hFFFF;
  assign wd = {fl_byte_n ? fl_dq_out[15:8] : 8'hFF, fl_dq_out[7:0]};
  always @(posedge sys_clk) begin
    we_q <= fl_we_n;
    if (!fl_oe_n && !fl_ce_n) held <= fl_dq_in;
    if (!fl_reset_n) begin
      busy <= 0;
      arm <= 1'b0;
    end else if (busy > 0) begin
      busy <= busy - 1;
    end else if (fl_we_n && !we_q && !fl_ce_n) begin
      last <= fl_dq_out[7:0];
      if (arm) begin
        mem[fl_addr[3:0]] <= mem[fl_addr[3:0]] & wd;
        busy <= BUSY_CYC;
        arm <= 1'b0;
      end else if (fl_dq_out[7:0] == 8'hA0) begin
        arm <= 1'b1;
      end else if (fl_dq_out[7:0] == 8'h20) begin
        byp <= 1'b1;
      end else if (last == 8'h90 && fl_dq_out[7:0] == 8'h00) begin
        byp <= 1'b0;
      end else if (fl_dq_out[7:0] == 8'h10 || fl_dq_out[7:0] == 8'h30) begin
        for (int i = 0; i < 16; i++) mem[i] <= 16'hFFFF;
        busy <= BUSY_CYC;
      end
    end
  end
  assign ready_busy_out_n = (busy == 0);
  // released bus shows inverse of last value
  assign fl_dq_in = (!fl_oe_n && !fl_ce_n) ? mem[fl_addr[3:0]] : ~held;
endmodule : fpc_flash_model
`default_nettype wire

// [fpc_host_asserts.sv]
// port checker for the flash command sequencer host
`default_nettype none
module fpc_host_asserts (
  input wire logic sys_clk, // clock
  input wire logic rst, // reset
  input wire logic [3:0] reg_addr, // register address
  input wire logic [31:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic [31:0] reg_rdata, // read data
  input wire logic [21:0] fl_addr, // flash address
  input wire logic [15:0] fl_dq_out, // flash data out
  input wire logic fl_dq_oe, // drive enable
  input wire logic fl_we_n, // write strobe
  input wire logic fl_oe_n, // output enable
  input wire logic fl_ce_n, // chip enable
  input wire logic fl_byte_n, // byte select
  input wire logic fl_reset_n // hardware reset
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_rst_idle: assert property (disable iff (1'b0) rst |=> fl_ce_n && fl_we_n && fl_oe_n && !fl_dq_oe && fl_reset_n && reg_rdata == 32'h0) else $error("outputs not idle after reset");
  a_we_width: assert property ($fell(fl_we_n) |-> !fl_we_n [*4] ##1 fl_we_n) else $error("write strobe width wrong");
  a_write_drive: assert property (!fl_we_n |-> fl_dq_oe && !fl_ce_n) else $error("write without drive");
  a_write_stable: assert property (!fl_we_n && $past(!fl_we_n) |-> $stable(fl_dq_out) && $stable(fl_addr)) else $error("write bus moved");
  a_read_quiet: assert property (!fl_oe_n |-> !fl_ce_n && !fl_dq_oe && fl_we_n) else $error("read cycle contention");
  a_reset_cause: assert property (reg_wr && reg_addr == 4'h0 && reg_wdata[31] |-> ##[1:3] !fl_reset_n) else $error("reset request lost");
  a_reset_pulse: assert property ($fell(fl_reset_n) |=> fl_reset_n) else $error("reset pulse too long");
  a_byte_hold: assert property (!fl_we_n |-> $stable(fl_byte_n)) else $error("byte select moved");
endmodule : fpc_host_asserts
bind fpc_host fpc_host_asserts u_chk (.sys_clk, .rst, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rdata, .fl_addr, .fl_dq_out, .fl_dq_oe, .fl_we_n, .fl_oe_n,
  .fl_ce_n, .fl_byte_n, .fl_reset_n);
`default_nettype wire

// [fpc_host_bench.sv]
// testbench for the flash command sequencer host
`default_nettype none
module fpc_host_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst, ce, reg_wr, reg_rd, fl_dq_oe, fl_we_n, fl_oe_n, fl_ce_n;
  logic fl_byte_n, fl_accel_hv, fl_reset_n, ready_busy_out_n;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic [21:0] fl_addr;
  logic [15:0] fl_dq_out, fl_dq_in;
  logic [1:0] ctl;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  fpc_host #(.WINDOW_CYC(50)) DUT (.sys_clk, .rst, .ce, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .fl_addr, .fl_dq_out, .fl_dq_oe, .fl_dq_in,
    .fl_we_n, .fl_oe_n, .fl_ce_n, .fl_byte_n, .fl_accel_hv, .fl_reset_n,
    .ready_busy_out_n);
  fpc_flash_model #(.BUSY_CYC(40)) u_flash (.sys_clk, .fl_addr, .fl_dq_out,
    .fl_we_n, .fl_oe_n, .fl_ce_n, .fl_byte_n, .fl_reset_n, .fl_dq_in,
    .ready_busy_out_n);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish();
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task bit_is(input int i, input logic e);
    rd(4'h3);
    chk({31'h0, v[i]}, {31'h0, e});
  endtask : bit_is
  task wait_bit(input int i, input logic e);
    rd(4'h3);
    while (v[i] !== e) rd(4'h3);
  endtask : wait_bit
  task op(input logic [3:0] o);
    wr(4'h0, {22'h0, ctl, 4'h0, o});
  endtask : op
  task prog(input logic [21:0] a, input logic [15:0] d, input logic [3:0] o);
    wr(4'h1, {10'h0, a});
    wr(4'h2, {16'h0, d});
    op(o);
    wait_bit(0, 1'b0);
  endtask : prog
  task rdflash(input logic [21:0] a, input logic [31:0] e);
    wr(4'h3, 32'h0);
    wr(4'h1, {10'h0, a});
    op(4'hD);
    wait_bit(6, 1'b1);
    rd(4'h4);
    chk(v, e);
  endtask : rdflash
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    ctl = 2'b01;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    bit_is(0, 1'b0);
    prog(22'h3, 16'h1234, 4'h1);
    rdflash(22'h3, 32'h1234);
    prog(22'h3, 16'hFFFF, 4'h1);
    rdflash(22'h3, 32'h1234);
    ctl = 2'b00;
    prog(22'h4, 16'hABCD, 4'h1);
    chk({31'h0, fl_byte_n}, 32'h0);
    ctl = 2'b01;
    op(4'h2);
    wait_bit(0, 1'b0);
    bit_is(3, 1'b1);
    prog(22'h5, 16'h0F0F, 4'h3);
    rdflash(22'h5, 32'h0F0F);
    op(4'h1);
    bit_is(4, 1'b1);
    op(4'h4);
    wait_bit(0, 1'b0);
    bit_is(3, 1'b0);
    wr(4'h3, 32'h0);
    op(4'hB);
    wait_bit(0, 1'b0);
    bit_is(2, 1'b1);
    ctl = 2'b11;
    op(4'h2);
    bit_is(4, 1'b1);
    chk({31'h0, fl_accel_hv}, 32'h0);
    op(4'hC);
    wait_bit(0, 1'b0);
    bit_is(2, 1'b0);
    op(4'hD);
    wait_bit(0, 1'b0);
    chk({31'h0, fl_accel_hv}, 32'h1);
    bit_is(3, 1'b1);
    ctl = 2'b01;
    op(4'hD);
    wait_bit(0, 1'b0);
    op(4'h4);
    wait_bit(0, 1'b0);
    bit_is(3, 1'b0);
    wr(4'h3, 32'h0);
    op(4'h5);
    op(4'h1);
    bit_is(4, 1'b1);
    wait_bit(0, 1'b0);
    rdflash(22'h3, 32'hFFFF);
    wr(4'h3, 32'h0);
    wr(4'h5, 32'h0);
    op(4'h6);
    wait_bit(1, 1'b1);
    op(4'h7);
    wait_bit(1, 1'b1);
    op(4'h1);
    bit_is(4, 1'b1);
    wait_bit(0, 1'b0);
    bit_is(7, 1'b1);
    wr(4'h3, 32'h0);
    op(4'h6);
    wait_bit(1, 1'b1);
    op(4'h8);
    wait_bit(0, 1'b0);
    bit_is(7, 1'b0);
    bit_is(4, 1'b0);
    wait_bit(5, 1'b0);
    op(4'hA);
    wait_bit(0, 1'b0);
    bit_is(4, 1'b0);
    wr(4'h1, 32'h6);
    wr(4'h2, 32'h0);
    op(4'h1);
    repeat (50) @(posedge sys_clk);
    wr(4'h0, 32'h8000_0000);
    wait_bit(0, 1'b0);
    bit_is(0, 1'b0);
    bit_is(5, 1'b0);
    tally_and_finish();
  end
endmodule : fpc_host_bench
`default_nettype wire
